// *** verilog/pwls_top.sv ***
// pwls_top: cpu window handshake, first-window identification, window
// timeout and front-panel indicators of a backplane serial module.
// assumes window strobes from the cpu and port events arrive asynchronously;
// the serial engine itself lives outside and obeys serial_enable and abort.
// Function
// - health led on when diagnostics pass
// - health off, failure code on others
// - toggle cpu link led per window
// - rx led flashes on receive, else on
// - tx led flashes on send, else on
// - port errors turn its leds off
// - fault output on only on window fault
// - no serial work before first window
// - first window reads cpu identity, sizes
// - five-second window timeout aborts exchange
// - executive windows from firmware 203 hex
// - clear command register after reading it
// - pulsed status held three windows minimum
`timescale 1ns/1ps
module pwls_top
	import pwls_pkg::*;
#(
	parameter int unsigned TIMEOUT_COUNT = WIN_TIMEOUT_CYC,
	parameter int unsigned FLASH_COUNT   = FLASH_CYC,
	parameter logic [11:0] FW_REV        = 12'h203
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        diag_done,
	input  wire logic [2:0]  diag_code,
	input  wire logic        window_open,
	input  wire logic        window_fault_in,
	input  wire logic        exec_mode,
	input  wire logic [15:0] cpu_id_in,
	input  wire logic [15:0] reg_size_in,
	input  wire logic [15:0] logic_size_in,
	input  wire logic [15:0] cmd_reg_in,
	input  wire logic        data_pending,
	input  wire logic        status_pulse_in,
	input  wire logic [1:0]  rx_char,
	input  wire logic [1:0]  tx_char,
	input  wire logic [1:0]  port_error,
	input  wire logic [1:0]  msg_ok,
	output logic             board_ok_led,
	output logic             cpu_link_led,
	output logic             port_a_rx_led,
	output logic             port_a_tx_led,
	output logic             port_b_rx_led,
	output logic             port_b_tx_led,
	output logic             window_fault,
	output logic             serial_enable,
	output logic             serial_abort,
	output logic             cmd_valid,
	output logic [15:0]      cmd_word,
	output logic             cmd_clear,
	output logic             status_pulse,
	output logic [15:0]      cpu_id,
	output logic [15:0]      reg_size,
	output logic [15:0]      logic_size
);
	if (TIMEOUT_COUNT < 2) begin : g_bad_timeout
		$error("pwls_top: TIMEOUT_COUNT too small");
	end

	// two-flop synchronisers for pins from the backplane and the ports
	logic [10:0] sync_a;
	logic [10:0] sync_b;
	logic        win_prev;
	always_ff @(posedge clk) begin
		if (reset) begin
			sync_a   <= 11'h000;
			sync_b   <= 11'h000;
			win_prev <= 1'b0;
		end else begin
			sync_a   <= {window_open, window_fault_in, exec_mode, rx_char, tx_char,
				port_error, msg_ok};
			sync_b   <= sync_a;
			win_prev <= sync_b[10];
		end
	end
	logic       win_s;
	logic       wfault_s;
	logic       exec_s;
	logic [1:0] rx_s;
	logic [1:0] tx_s;
	logic [1:0] err_s;
	logic [1:0] ok_s;
	assign {win_s, wfault_s, exec_s, rx_s, tx_s, err_s, ok_s} = sync_b;
	logic win_close;
	assign win_close = win_prev & ~win_s;

	// executive windows only honoured by capable firmware
	logic exec_ok;
	assign exec_ok = exec_s & (FW_REV >= EXEC_MIN_FW_REV);

	pwls_state_e state;
	pwls_state_e next_state;
	logic [31:0] tmo_cnt;
	logic [31:0] next_tmo_cnt;
	logic [1:0]  pulse_wins;
	logic [1:0]  next_pulse_wins;
	logic        next_board_ok_led;
	logic        next_cpu_link_led;
	logic        next_window_fault;
	logic        next_serial_enable;
	logic        next_serial_abort;
	logic        next_cmd_valid;
	logic [15:0] next_cmd_word;
	logic        next_cmd_clear;
	logic        next_status_pulse;
	logic [15:0] next_cpu_id;
	logic [15:0] next_reg_size;
	logic [15:0] next_logic_size;
	logic        leds_on;

	always_comb begin
		next_state         = state;
		next_tmo_cnt       = tmo_cnt;
		next_pulse_wins    = pulse_wins;
		next_board_ok_led  = board_ok_led;
		next_cpu_link_led  = cpu_link_led;
		next_window_fault  = window_fault;
		next_serial_enable = serial_enable;
		next_serial_abort  = 1'b0;
		next_cmd_valid     = 1'b0;
		next_cmd_word      = cmd_word;
		next_cmd_clear     = 1'b0;
		next_status_pulse  = status_pulse;
		next_cpu_id        = cpu_id;
		next_reg_size      = reg_size;
		next_logic_size    = logic_size;
		case (state)
			PWLS_ST_WAIT_FIRST: begin
				if (diag_done && diag_code != DIAG_OK) begin
					next_state        = PWLS_ST_FAIL;
					next_board_ok_led = 1'b0;
				end else if (diag_done) begin
					next_board_ok_led = 1'b1;
					if (win_s) begin
						next_state = PWLS_ST_IDENT;
					end
				end
			end
			PWLS_ST_IDENT: begin
				// identity is latched during the first window, at its close
				if (win_close) begin
					next_cpu_id        = cpu_id_in;
					next_reg_size      = reg_size_in;
					next_logic_size    = logic_size_in;
					next_serial_enable = 1'b1;
					next_cpu_link_led  = ~cpu_link_led;
					next_window_fault  = wfault_s;
					next_state         = PWLS_ST_RUN;
				end
			end
			PWLS_ST_RUN: begin
				if (win_close) begin
					next_cpu_link_led = ~cpu_link_led;
					next_window_fault = wfault_s;
					next_tmo_cnt      = 32'h0;
					if (cmd_reg_in != CMD_IDLE) begin
						next_cmd_valid = 1'b1;
						next_cmd_word  = cmd_reg_in;
						next_cmd_clear = 1'b1;
					end
					if (pulse_wins != 2'h0) begin
						next_pulse_wins = pulse_wins - 2'h1;
					end
				end else if (data_pending && !win_s) begin
					if (tmo_cnt >= TIMEOUT_COUNT - 1) begin
						next_serial_abort = 1'b1;
						next_tmo_cnt      = 32'h0;
					end else begin
						next_tmo_cnt = tmo_cnt + 32'h1;
					end
				end else if (!data_pending) begin
					next_tmo_cnt = 32'h0;
				end
				if (status_pulse_in) begin
					next_status_pulse = 1'b1;
					next_pulse_wins   = 2'(PULSE_MIN_WIN);
				end else if (pulse_wins == 2'h0) begin
					next_status_pulse = 1'b0;
				end
			end
			PWLS_ST_FAIL: begin
				next_board_ok_led  = 1'b0;
				next_cpu_link_led  = 1'b0;
				next_serial_enable = 1'b0;
			end
			default: begin
				next_state = PWLS_ST_WAIT_FIRST;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state         <= PWLS_ST_WAIT_FIRST;
			tmo_cnt       <= 32'h0;
			pulse_wins    <= 2'h0;
			board_ok_led  <= 1'b0;
			cpu_link_led  <= 1'b0;
			window_fault  <= 1'b0;
			serial_enable <= 1'b0;
			serial_abort  <= 1'b0;
			cmd_valid     <= 1'b0;
			cmd_word      <= 16'h0000;
			cmd_clear     <= 1'b0;
			status_pulse  <= 1'b0;
			cpu_id        <= 16'h0000;
			reg_size      <= 16'h0000;
			logic_size    <= 16'h0000;
		end else begin
			state         <= next_state;
			tmo_cnt       <= next_tmo_cnt;
			pulse_wins    <= next_pulse_wins;
			board_ok_led  <= next_board_ok_led;
			cpu_link_led  <= next_cpu_link_led;
			window_fault  <= next_window_fault;
			serial_enable <= next_serial_enable;
			serial_abort  <= next_serial_abort;
			cmd_valid     <= next_cmd_valid;
			cmd_word      <= next_cmd_word;
			cmd_clear     <= next_cmd_clear;
			status_pulse  <= next_status_pulse;
			cpu_id        <= next_cpu_id;
			reg_size      <= next_reg_size;
			logic_size    <= next_logic_size;
		end
	end

	// port leds run once the first window enables serial, or in executive mode; on failure they show the code
	logic [1:0] a_leds;
	logic [1:0] b_leds;
	assign leds_on = serial_enable | exec_ok;
	pwls_port_leds #(.FLASH_COUNT(FLASH_COUNT)) u_port_a (
		.clk       (clk),
		.reset     (reset),
		.enable    (leds_on),
		.rx_char   (rx_s[0]),
		.tx_char   (tx_s[0]),
		.port_error(err_s[0]),
		.msg_ok    (ok_s[0]),
		.rx_led    (a_leds[1]),
		.tx_led    (a_leds[0])
	);
	pwls_port_leds #(.FLASH_COUNT(FLASH_COUNT)) u_port_b (
		.clk       (clk),
		.reset     (reset),
		.enable    (leds_on),
		.rx_char   (rx_s[1]),
		.tx_char   (tx_s[1]),
		.port_error(err_s[1]),
		.msg_ok    (ok_s[1]),
		.rx_led    (b_leds[1]),
		.tx_led    (b_leds[0])
	);

	// failure code drives the port leds directly; registered to keep outputs clean
	logic [3:0] code_leds;
	always_comb begin
		case (diag_code)
			3'h1: code_leds = 4'h0;
			3'h2: code_leds = 4'h1;
			3'h3: code_leds = 4'h2;
			3'h4: code_leds = 4'h3;
			3'h5: code_leds = 4'h4;
			3'h6: code_leds = 4'h5;
			3'h7: code_leds = 4'hD;
			default: code_leds = 4'h0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			{port_a_rx_led, port_a_tx_led, port_b_rx_led, port_b_tx_led} <= 4'h0;
		end else if (state == PWLS_ST_FAIL) begin
			{port_a_rx_led, port_a_tx_led, port_b_rx_led, port_b_tx_led} <= code_leds;
		end else begin
			{port_a_rx_led, port_a_tx_led, port_b_rx_led, port_b_tx_led} <= {a_leds, b_leds};
		end
	end
endmodule // pwls_top

// *** verilog/pwls_pkg.sv ***
// pwls_pkg: constants shared by the window-link status block.
// assumes a 10 MHz system clock.
package pwls_pkg;
	localparam int unsigned CLK_HZ           = 10000000;
	localparam int unsigned WIN_TIMEOUT_MS   = 5000;
	localparam int unsigned WIN_TIMEOUT_CYC  = (CLK_HZ / 1000) * WIN_TIMEOUT_MS;
	localparam int unsigned FLASH_MS         = 100;
	localparam int unsigned FLASH_CYC        = (CLK_HZ / 1000) * FLASH_MS;
	localparam int unsigned PULSE_MIN_WIN    = 3;
	localparam logic [15:0] WIN_REQ_OFFSET   = 16'h03E8;
	localparam logic [15:0] EXEC_CMD_REG     = 16'h03F1;
	localparam logic [11:0] EXEC_MIN_FW_REV  = 12'h203;
	localparam logic [15:0] CMD_IDLE         = 16'h0000;
	localparam logic [2:0]  DIAG_OK          = 3'h0;

	typedef enum logic [1:0] {
		PWLS_ST_WAIT_FIRST = 2'b00,
		PWLS_ST_IDENT      = 2'b01,
		PWLS_ST_RUN        = 2'b10,
		PWLS_ST_FAIL       = 2'b11
	} pwls_state_e;
endpackage

// *** verilog/pwls_port_leds.sv ***
// pwls_port_leds: receive and transmit indicators of one serial port.
// assumes activity and error pulses come from logic on the same clock.
`timescale 1ns/1ps
module pwls_port_leds
	import pwls_pkg::*;
#(
	parameter int unsigned FLASH_COUNT = FLASH_CYC
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic enable,
	input  wire logic rx_char,
	input  wire logic tx_char,
	input  wire logic port_error,
	input  wire logic msg_ok,
	output logic      rx_led,
	output logic      tx_led
);
	// a flash needs at least two counts to show both halves
	if (FLASH_COUNT < 2) begin : g_bad_flash
		$error("pwls_port_leds: FLASH_COUNT too small");
	end

	logic [31:0] rx_cnt;
	logic [31:0] tx_cnt;
	logic        faulted;
	logic [31:0] next_rx_cnt;
	logic [31:0] next_tx_cnt;
	logic        next_faulted;
	logic        next_rx_led;
	logic        next_tx_led;

	always_comb begin
		next_faulted = faulted;
		if (port_error) begin
			next_faulted = 1'b1;
		end else if (msg_ok) begin
			next_faulted = 1'b0;
		end
		// activity restarts the flash window; led blinks while counting down
		next_rx_cnt = rx_char ? FLASH_COUNT : ((rx_cnt != 32'h0) ? rx_cnt - 32'h1 : 32'h0);
		next_tx_cnt = tx_char ? FLASH_COUNT : ((tx_cnt != 32'h0) ? tx_cnt - 32'h1 : 32'h0);
		next_rx_led = rx_led;
		next_tx_led = tx_led;
		if (!enable || next_faulted) begin
			next_rx_led = 1'b0;
			next_tx_led = 1'b0;
		end else begin
			if (rx_cnt == 32'h0) begin
				next_rx_led = 1'b1;
			end else if (rx_cnt == FLASH_COUNT || rx_cnt == (FLASH_COUNT >> 1)) begin
				next_rx_led = ~rx_led;
			end
			if (tx_cnt == 32'h0) begin
				next_tx_led = 1'b1;
			end else if (tx_cnt == FLASH_COUNT || tx_cnt == (FLASH_COUNT >> 1)) begin
				next_tx_led = ~tx_led;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_cnt  <= 32'h0;
			tx_cnt  <= 32'h0;
			faulted <= 1'b0;
			rx_led  <= 1'b0;
			tx_led  <= 1'b0;
		end else begin
			rx_cnt  <= next_rx_cnt;
			tx_cnt  <= next_tx_cnt;
			faulted <= next_faulted;
			rx_led  <= next_rx_led;
			tx_led  <= next_tx_led;
		end
	end
endmodule // pwls_port_leds

// *** sim/pwls_top_sva.sv ***
// pwls_top_chk: port-level assertions for pwls_top.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pwls_top_chk
	import pwls_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        diag_done,
	input wire logic [2:0]  diag_code,
	input wire logic        window_open,
	input wire logic        data_pending,
	input wire logic [1:0]  port_error,
	input wire logic        board_ok_led,
	input wire logic        cpu_link_led,
	input wire logic        port_a_rx_led,
	input wire logic        port_a_tx_led,
	input wire logic        window_fault,
	input wire logic        serial_enable,
	input wire logic        serial_abort,
	input wire logic        cmd_valid,
	input wire logic [15:0] cmd_word,
	input wire logic        cmd_clear
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_health_pass: assert property (diag_done && diag_code == DIAG_OK |-> ##[1:4] board_ok_led)
		else $error("health led not on");
	a_health_fail: assert property (diag_done && diag_code != DIAG_OK |-> ##[1:4] !board_ok_led)
		else $error("health led not off");
	a_link_cause: assert property ($changed(cpu_link_led) |-> !$past(window_open))
		else $error("link led moved inside window");
	a_enable_first: assert property ($rose(serial_enable) |-> $changed(cpu_link_led))
		else $error("serial enabled without window");
	a_fault_close: assert property ($changed(window_fault) |-> $changed(cpu_link_led))
		else $error("fault moved outside close");
	a_port_off: assert property (port_error[0] |-> ##[1:5] !(port_a_rx_led || port_a_tx_led))
		else $error("port leds stay on");
	a_abort_cause: assert property (serial_abort |-> $past(data_pending) && !$past(window_open, 3))
		else $error("abort without cause");
	a_abort_once: assert property (serial_abort |=> !serial_abort)
		else $error("abort too long");
	a_cmd_clear: assert property (cmd_valid |-> cmd_clear && cmd_word != CMD_IDLE)
		else $error("command not cleared");
	a_clear_once: assert property (cmd_clear |=> !cmd_clear)
		else $error("clear too long");
endmodule // pwls_top_chk

bind pwls_top pwls_top_chk chk (.clk(clk), .reset(reset), .diag_done(diag_done),
	.diag_code(diag_code), .window_open(window_open), .data_pending(data_pending),
	.port_error(port_error), .board_ok_led(board_ok_led), .cpu_link_led(cpu_link_led),
	.port_a_rx_led(port_a_rx_led), .port_a_tx_led(port_a_tx_led),
	.window_fault(window_fault), .serial_enable(serial_enable),
	.serial_abort(serial_abort), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
	.cmd_clear(cmd_clear));

// *** sim/pwls_cpu_model.sv ***
// pwls_cpu_model: cpu side that grants windows and owns the command register.
// assumes the bench drives grant and load on the rising edge.
`timescale 1ns/1ps
module pwls_cpu_model (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        grant,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	input  wire logic        cmd_clear,
	output logic             window_open,
	output logic [15:0]      cmd_reg
);
	// request operand names this module: its first input point plus 1000
	localparam logic [15:0] FIRST_POINT = 16'h0001;
	localparam logic [15:0] REQ_OPERAND = FIRST_POINT + 16'h03E8;
	// the alternative window instruction is only legal on newer cpu microcode
	localparam int unsigned UCODE_VER   = 130;
	localparam bit          USE_ALT_WIN = 1'b0;
	if (USE_ALT_WIN && UCODE_VER < 130) begin : g_bad_ucode
		$error("pwls_cpu_model: alternative window needs newer microcode");
	end
	logic       req_ok;
	assign req_ok = (REQ_OPERAND == 16'h03E9);
	logic [3:0] cnt;
	// six cycles open, then at least eight closed so each close is seen apart
	always_ff @(posedge clk) begin
		if (reset) begin
			window_open <= 1'b0;
			cnt         <= 4'h0;
		end else if (window_open) begin
			window_open <= (cnt != 4'h5);
			cnt         <= (cnt == 4'h5) ? 4'h0 : cnt + 4'h1;
		end else if (cnt < 4'h8) begin
			cnt <= cnt + 4'h1;
		end else if (grant && req_ok) begin
			window_open <= 1'b1;
			cnt         <= 4'h0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset)
			cmd_reg <= 16'h0000;
		else if (load)
			cmd_reg <= load_val;
		else if (cmd_clear)
			cmd_reg <= 16'h0000;
	end
endmodule // pwls_cpu_model

// *** sim/test_plc_window_link_status.sv ***
// test_plc_window_link_status: directed bench for pwls_top with a cpu model.
// assumes short timeout and flash counts set at the instance.
`timescale 1ns/1ps
module test_plc_window_link_status;
	import pwls_pkg::*;
	localparam logic [15:0] ID_V = 16'h00A5; // arbitrary value
	localparam logic [27:0] PAT  = 28'hD543210;
	logic        clk = 1'b0, reset = 1'b1, diag_done = 1'b1;
	logic [2:0]  diag_code = 3'h0;
	logic        grant = 1'b0, fault = 1'b0, load = 1'b0, pend = 1'b0, st_in = 1'b0, ex = 1'b0;
	logic [15:0] load_val = 16'h0000, cmd_reg, cmd_word, cid, rs, ls, got;
	logic [7:0]  ev = 8'h00;
	logic        win, ok, link, a_rx, a_tx, b_rx, b_tx, wf, sen, sab, cv, cc, sp;
	int          miscompares = 0, n_tests = 0, cyc = 0;
	pwls_top #(.TIMEOUT_COUNT(200), .FLASH_COUNT(8)) DUT (.clk(clk), .reset(reset),
		.diag_done(diag_done), .diag_code(diag_code), .window_open(win),
		.window_fault_in(fault), .exec_mode(ex), .cpu_id_in(ID_V),
		.reg_size_in(16'h0400), .logic_size_in(16'h0800), .cmd_reg_in(cmd_reg),
		.data_pending(pend), .status_pulse_in(st_in), .rx_char(ev[1:0]),
		.tx_char(ev[3:2]), .port_error(ev[5:4]), .msg_ok(ev[7:6]), .board_ok_led(ok),
		.cpu_link_led(link), .port_a_rx_led(a_rx), .port_a_tx_led(a_tx),
		.port_b_rx_led(b_rx), .port_b_tx_led(b_tx), .window_fault(wf),
		.serial_enable(sen), .serial_abort(sab), .cmd_valid(cv), .cmd_word(cmd_word),
		.cmd_clear(cc), .status_pulse(sp), .cpu_id(cid), .reg_size(rs), .logic_size(ls));
	pwls_cpu_model cpu (.clk(clk), .reset(reset), .grant(grant), .load(load),
		.load_val(load_val), .cmd_clear(cc), .window_open(win), .cmd_reg(cmd_reg));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (cv)
			got <= cmd_word;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("FAIL %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic do_reset;
		reset <= 1'b1;
		tick(8);
		reset <= 1'b0;
		tick(6);
	endtask
	task automatic one_win;
		grant <= 1'b1;
		for (int i = 0; i < 40 && win !== 1'b1; i++) tick(1);
		grant <= 1'b0;
		tick(14);
	endtask
	function automatic logic [1:0] leds(input int p);
		return p ? {b_rx, b_tx} : {a_rx, a_tx};
	endfunction
	// event pulse three cycles wide; returns which leds dropped meanwhile
	task automatic pulse(input int b, input int p, output logic [1:0] lo);
		lo = 2'b00;
		ev[b] <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			tick(1);
			if (i == 2)
				ev[b] <= 1'b0;
			lo = lo | ~leds(p);
		end
	endtask
	task automatic t_diag;
		for (int c = 1; c < 8; c++) begin
			diag_code <= c[2:0];
			do_reset;
			chk("board_ok", ok, 0);
			chk("link_off", link, 0);
			chk("pattern", {a_rx, a_tx, b_rx, b_tx}, PAT[4*(c-1)+:4]);
		end
		diag_code <= DIAG_OK;
		do_reset;
		chk("board_ok", ok, 1);
		chk("serial_enable", sen, 0);
		chk("idle_leds", leds(0), 2'b00);
		// executive address is only set while the module is held in reset
		ex <= 1'b1;
		do_reset;
		chk("exec_leds", leds(0), 2'b11);
		chk("serial_enable", sen, 0);
		ex <= 1'b0;
		do_reset;
	endtask
	task automatic t_windows;
		logic l;
		l = link;
		one_win;
		chk("serial_enable", sen, 1);
		chk("cpu_id", cid, ID_V);
		chk("reg_size", rs, 16'h0400);
		chk("logic_size", ls, 16'h0800);
		chk("link", link, !l);
		chk("fault", wf, 0);
		fault <= 1'b1;
		one_win;
		chk("link", link, l);
		chk("fault", wf, 1);
		fault <= 1'b0;
		one_win;
		chk("fault", wf, 0);
	endtask
	task automatic t_cmd;
		load_val <= 16'h0005;
		load <= 1'b1;
		tick(1);
		load <= 1'b0;
		one_win;
		chk("cmd_word", got, 16'h0005);
		chk("cmd_reg", cmd_reg, 16'h0000);
	endtask
	task automatic t_status;
		st_in <= 1'b1;
		tick(1);
		st_in <= 1'b0;
		tick(3);
		one_win;
		one_win;
		chk("status", sp, 1);
		one_win;
		one_win;
		chk("status", sp, 0);
	endtask
	task automatic t_ports;
		logic [1:0] lo;
		for (int p = 0; p < 2; p++) begin
			pulse(6 + p, p, lo);
			chk("leds", leds(p), 2'b11);
			pulse(p, p, lo);
			chk("rx_flash", lo[1], 1);
			pulse(2 + p, p, lo);
			chk("tx_flash", lo[0], 1);
			pulse(4 + p, p, lo);
			chk("leds_err", leds(p), 2'b00);
			pulse(6 + p, p, lo);
			chk("leds", leds(p), 2'b11);
		end
	endtask
	task automatic t_timeout;
		int n;
		pend <= 1'b1;
		for (n = 0; n < 400 && sab !== 1'b1; n++) tick(1);
		pend <= 1'b0;
		chk("abort_time", n >= 190 && n <= 215, 1);
	endtask
	initial begin
		t_diag;
		$display("diag test done");
		t_windows;
		$display("window test done");
		t_cmd;
		$display("command test done");
		t_status;
		$display("status test done");
		t_ports;
		$display("port test done");
		t_timeout;
		$display("timeout test done");
		close_out;
	end
endmodule // test_plc_window_link_status
